// File: bench/tb.sv
// Purpose: self-checking bench for the port C/D/E output-enable registers
// Assumes: single ahb-lite master in the bench, hreadyout fed back to hready
// Notes:   expected register contents are kept in a bench-side shadow
module tb
  import port_oe_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic              hclk    = 1'b0;
  logic              hresetn = 1'b0;
  logic              hsel    = 1'b0;
  logic [DATA_W-1:0] haddr   = 32'h0000_0000;
  logic [1:0]        htrans  = 2'h0;
  logic              hwrite  = 1'b0;
  logic [2:0]        hsize   = 3'h2;
  logic [DATA_W-1:0] hwdata  = 32'h0000_0000;
  logic [DATA_W-1:0] hrdata;
  logic              hreadyout;
  logic              hresp;
  logic [PORT_W-1:0] drv [NUM_PORTS];
  logic [PORT_W-1:0] shadow [NUM_PORTS];
  logic [DATA_W-1:0] rd;
  logic [7:0]        pats [6] = '{8'h01, 8'h80, 8'hA5, 8'h5A, 8'hFF, 8'h00};
  int                n_mismatch = 0;
  int                cmp_count  = 0;
  int                cycles     = 0;

  always #2.5 hclk = ~hclk;

  port_output_enable_cde port_output_enable_cde_i (
    .hclk             (hclk),
    .hresetn          (hresetn),
    .hsel             (hsel),
    .haddr            (haddr),
    .htrans           (htrans),
    .hwrite           (hwrite),
    .hsize            (hsize),
    .hready           (hreadyout),
    .hwdata           (hwdata),
    .hrdata           (hrdata),
    .hreadyout        (hreadyout),
    .hresp            (hresp),
    .port_c_drive_bit (drv[SLOT_C]),
    .port_d_drive_bit (drv[SLOT_D]),
    .port_e_drive_bit (drv[SLOT_E])
  );

  task automatic final_report();
    $display("checks %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  always @(posedge hclk) begin
    cycles++;
    if (cycles == 4000) begin
      n_mismatch++;
      final_report();
    end
  end

  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wait_ready();
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask

  // one single transfer: address phase, then data phase
  task automatic bus(logic w, logic [31:0] a, logic [2:0] s,
                     logic [31:0] wd, output logic [31:0] q);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    hsize  <= s;
    wait_ready();
    htrans <= HTRANS_IDLE;
    hwdata <= wd;
    wait_ready();
    q = hrdata;
    check("hresp", {31'h0, hresp}, {31'h0, HRESP_OKAY});
    check("hreadyout", {31'h0, hreadyout}, 32'h0000_0001);
  endtask

  function automatic logic [31:0] addr_of(int i);
    return {PORT_IDX[i], 2'b00};
  endfunction

  // read every register back and compare it and the pads to the shadow
  task automatic check_all(string tname);
    for (int i = 0; i < NUM_PORTS; i++) begin
      bus(1'b0, addr_of(i), HSIZE_WORD, 32'h0, rd);
      check("readback", rd, {24'h0, shadow[i]});
    end
    check("pads_c", {24'h0, drv[SLOT_C]}, {24'h0, shadow[0]});
    check("pads_d", {24'h0, drv[SLOT_D]}, {24'h0, shadow[1]});
    check("pads_e", {24'h0, drv[SLOT_E]}, {24'h0, shadow[2]});
    $display("test %s done", tname);
  endtask

  initial begin
    shadow = '{8'h00, 8'h00, 8'h00};
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    check_all("reset_values");
    // each pattern xor the port slot to each port, upper data lanes set to junk
    foreach (pats[k]) begin
      for (int i = 0; i < NUM_PORTS; i++) begin
        shadow[i] = pats[k] ^ 8'(i);
        bus(1'b1, addr_of(i), HSIZE_WORD, {24'hFFFFFF, shadow[i]}, rd);
      end
      check_all("patterns");
    end
    // neighbouring unmapped words write nothing; the word above port E reads zero
    bus(1'b1, addr_of(0) - 32'h4, HSIZE_WORD, 32'hFFFF_FFFF, rd);
    bus(1'b1, addr_of(2) + 32'h4, HSIZE_WORD, 32'hFFFF_FFFF, rd);
    bus(1'b0, addr_of(2) + 32'h4, HSIZE_WORD, 32'h0, rd);
    check("unmapped", rd, RDATA_NONE);
    check_all("unmapped");
    // byte write off lane 0 is dropped, byte write on lane 0 lands
    bus(1'b1, addr_of(1) + 32'h1, HSIZE_BYTE, 32'hFFFF_FFFF, rd);
    shadow[1] = 8'h3C;
    bus(1'b1, addr_of(1), HSIZE_BYTE, 32'h0000_003C, rd);
    check_all("byte_lanes");
    // a read right after a write to the same register sees the new value
    for (int i = 0; i < NUM_PORTS; i++) begin
      shadow[i] = 8'h96 ^ 8'(i);
      bus(1'b1, addr_of(i), HSIZE_WORD, {24'h0, shadow[i]}, rd);
      bus(1'b0, addr_of(i), HSIZE_WORD, 32'h0, rd);
      check("write_read", rd, {24'h0, shadow[i]});
    end
    $display("test write_read done");
    // reset in mid-run clears every enable
    for (int i = 0; i < NUM_PORTS; i++) begin
      bus(1'b1, addr_of(i), HSIZE_WORD, 32'h0000_00FF, rd);
    end
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    check("rst_pads_c", {24'h0, drv[SLOT_C]}, {24'h0, RESET_DRIVE});
    check("rst_pads_d", {24'h0, drv[SLOT_D]}, {24'h0, RESET_DRIVE});
    check("rst_hrdata", hrdata, RDATA_NONE);
    check("rst_pads_e", {24'h0, drv[SLOT_E]}, {24'h0, RESET_DRIVE});
    hresetn <= 1'b1;
    @(posedge hclk);
    shadow = '{8'h00, 8'h00, 8'h00};
    check_all("mid_reset");
    final_report();
  end
endmodule

// File: rtl/ahb_reg_slave.sv
// Purpose: ahb-lite address and data phase tracking for the register file
// Assumes: zero wait states, single transfers
// Notes:   write takes effect at the edge that ends its data phase
module ahb_reg_slave
  import port_oe_pkg::*;
(
  // clock and reset
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  // ahb-lite address phase
  input  wire logic                  hsel,
  input  wire logic [DATA_W-1:0]     haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic                  hready,
  // ahb-lite data phase
  input  wire logic [DATA_W-1:0]     hwdata,
  // register side
  reg_access_if.bus                  acc
);
  logic             accept;
  logic             lane0_hit;
  logic             wr_pending;
  logic [IDX_W-1:0] wr_index_q;
  logic             wr_lane0_q;

  assign accept    = hsel & hready & htrans[1];
  assign lane0_hit = (hsize == HSIZE_WORD)
                   | ((hsize == HSIZE_HALF) & ~haddr[1])
                   | ((hsize == HSIZE_BYTE) & (haddr[1:0] == 2'h0));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pending <= 1'b0;
      wr_index_q <= '0;
      wr_lane0_q <= 1'b0;
    end else if (hready) begin
      wr_pending <= accept & hwrite;
      wr_index_q <= haddr[DATA_W-1:2];
      wr_lane0_q <= lane0_hit;
    end
  end

  assign acc.rd_req   = accept & ~hwrite;
  assign acc.rd_index = haddr[DATA_W-1:2];
  assign acc.wr_req   = wr_pending & hready;
  assign acc.wr_index = wr_index_q;
  assign acc.wr_lane0 = wr_lane0_q;
  assign acc.wr_data  = hwdata[PORT_W-1:0];
endmodule

// File: rtl/drive_enable_bank.sv
// Purpose: one port's output-driver enable register
// Assumes: write strobe already decoded for this port
// Notes:   next_q lets a read in the same edge see the new value
module drive_enable_bank #(
  parameter int                WIDTH       = 8,
  parameter logic [WIDTH-1:0]  RESET_VALUE = '0
) (
  // clock and reset
  input  wire logic             hclk,
  input  wire logic             hresetn,
  // write port
  input  wire logic             wr_en,
  input  wire logic [WIDTH-1:0] wr_data,
  // enable state
  output logic      [WIDTH-1:0] q,
  output logic      [WIDTH-1:0] next_q
);
  assign next_q = wr_en ? wr_data : q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= RESET_VALUE;
    end else begin
      q <= next_q;
    end
  end
endmodule

// File: rtl/port_oe_pkg.sv
// Purpose: shared constants for the port C/D/E output-enable block
// Assumes: AHB-Lite slave, 32-bit data, one aligned word per register
// Notes:   register index times four is the byte address on the bus
//
// Notes on behaviour
// - port C enable register at index 30B2h; bit n enables port C pin n.
// - port D enable register at index 30B3h; bit n enables port D pin n.
// - port E enable register at index 30B4h; bit n enables port E pin n.
// - enable bit 0 keeps the pin driver off; 1 drives the pin.
// - every enable bit is software writable and reads back the last write.
package port_oe_pkg;

  localparam int DATA_W    = 32;
  localparam int PORT_W    = 8;
  localparam int IDX_W     = 30;
  localparam int NUM_PORTS = 3;

  // register indices; byte address is index times four
  localparam logic [IDX_W-1:0] IDX_PORT_C = 30'h0000_30B2;
  localparam logic [IDX_W-1:0] IDX_PORT_D = 30'h0000_30B3;
  localparam logic [IDX_W-1:0] IDX_PORT_E = 30'h0000_30B4;
  localparam logic [IDX_W-1:0] PORT_IDX [NUM_PORTS] = '{
    IDX_PORT_C, IDX_PORT_D, IDX_PORT_E
  };

  localparam logic [PORT_W-1:0] RESET_DRIVE = 8'h00;
  localparam logic [DATA_W-1:0] RDATA_NONE  = 32'h0000_0000;

  // ahb encodings
  localparam logic [1:0] HTRANS_IDLE   = 2'h0;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_BYTE    = 3'h0;
  localparam logic [2:0] HSIZE_HALF    = 3'h1;
  localparam logic [2:0] HSIZE_WORD    = 3'h2;
  localparam logic       HRESP_OKAY    = 1'b0;

  // index of each port in the bank array
  localparam int SLOT_C = 0;
  localparam int SLOT_D = 1;
  localparam int SLOT_E = 2;

endpackage

// File: rtl/port_output_enable_cde.sv
// Purpose: output-driver enable registers of ports C, D and E
// Assumes: sole slave on an ahb-lite bus, hreadyout feeds hready
// Notes:   each enable bit drives the pad output enable of its pin
module port_output_enable_cde
  import port_oe_pkg::*;
(
  // clock and reset
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  // ahb-lite slave
  input  wire logic                  hsel,
  input  wire logic [DATA_W-1:0]     haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic                  hready,
  input  wire logic [DATA_W-1:0]     hwdata,
  output logic      [DATA_W-1:0]     hrdata,
  output logic                       hreadyout,
  output logic                       hresp,
  // pad output enables, high drives the pin
  output logic      [PORT_W-1:0]     port_c_drive_bit,
  output logic      [PORT_W-1:0]     port_d_drive_bit,
  output logic      [PORT_W-1:0]     port_e_drive_bit
);
  import port_oe_pkg::*;

  reg_access_if acc ();

  logic [PORT_W-1:0]    drive_q   [NUM_PORTS];
  logic [PORT_W-1:0]    drive_nxt [NUM_PORTS];
  logic [NUM_PORTS-1:0] wr_hit;
  logic [NUM_PORTS-1:0] rd_hit;
  logic [NUM_PORTS-1:0] wr_en;
  logic                 rd_mapped;
  logic [PORT_W-1:0]    rd_byte;
  logic [DATA_W-1:0]    next_hrdata;

  // bus front end
  ahb_reg_slave u_slave (
    .hclk    (hclk),
    .hresetn (hresetn),
    .hsel    (hsel),
    .haddr   (haddr),
    .htrans  (htrans),
    .hwrite  (hwrite),
    .hsize   (hsize),
    .hready  (hready),
    .hwdata  (hwdata),
    .acc     (acc.bus)
  );

  // one enable register per port
  for (genvar g = 0; g < NUM_PORTS; g++) begin : g_port
    assign wr_hit[g] = (acc.wr_index == PORT_IDX[g]);
    assign rd_hit[g] = (acc.rd_index == PORT_IDX[g]);
    assign wr_en[g]  = acc.wr_req & acc.wr_lane0 & wr_hit[g];

    drive_enable_bank #(
      .WIDTH       (PORT_W),
      .RESET_VALUE (RESET_DRIVE)
    ) u_bank (
      .hclk    (hclk),
      .hresetn (hresetn),
      .wr_en   (wr_en[g]),
      .wr_data (acc.wr_data),
      .q       (drive_q[g]),
      .next_q  (drive_nxt[g])
    );
  end

  // pad enables come straight from the bank flops
  assign port_c_drive_bit = drive_q[SLOT_C];
  assign port_d_drive_bit = drive_q[SLOT_D];
  assign port_e_drive_bit = drive_q[SLOT_E];

  // read select uses the post-write value so back to back access is exact
  assign rd_mapped = |rd_hit;
  assign rd_byte   = ({PORT_W{rd_hit[SLOT_C]}} & drive_nxt[SLOT_C])
                   | ({PORT_W{rd_hit[SLOT_D]}} & drive_nxt[SLOT_D])
                   | ({PORT_W{rd_hit[SLOT_E]}} & drive_nxt[SLOT_E]);
  assign next_hrdata = rd_mapped
                     ? {{(DATA_W-PORT_W){1'b0}}, rd_byte}
                     : RDATA_NONE;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= RDATA_NONE;
    end else if (acc.rd_req) begin
      hrdata <= next_hrdata;
    end
  end

  // zero wait states, always okay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= HRESP_OKAY;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= HRESP_OKAY;
    end
  end

  // helpers for the checks below
  logic              rd_c_q;
  logic              rd_d_q;
  logic              rd_e_q;
  logic              rd_none_q;
  logic [PORT_W-1:0] wdata_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_c_q    <= 1'b0;
      rd_d_q    <= 1'b0;
      rd_e_q    <= 1'b0;
      rd_none_q <= 1'b0;
      wdata_q   <= '0;
    end else begin
      rd_c_q    <= acc.rd_req & rd_hit[SLOT_C];
      rd_d_q    <= acc.rd_req & rd_hit[SLOT_D];
      rd_e_q    <= acc.rd_req & rd_hit[SLOT_E];
      rd_none_q <= acc.rd_req & ~rd_mapped;
      wdata_q   <= acc.wr_data;
    end
  end

  reset_clear_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    $rose(hresetn) |->
      (port_c_drive_bit == RESET_DRIVE) &&
      (port_d_drive_bit == RESET_DRIVE) &&
      (port_e_drive_bit == RESET_DRIVE)
  ) else $error("enable bits not cleared after reset");

  write_port_c_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (acc.wr_req && acc.wr_lane0 && acc.wr_index == IDX_PORT_C) |=>
      (port_c_drive_bit == wdata_q)
  ) else $error("port c enable did not take written value");

  write_port_d_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (acc.wr_req && acc.wr_lane0 && acc.wr_index == IDX_PORT_D) |=>
      (port_d_drive_bit == wdata_q)
  ) else $error("port d enable did not take written value");

  write_port_e_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (acc.wr_req && acc.wr_lane0 && acc.wr_index == IDX_PORT_E) |=>
      (port_e_drive_bit == wdata_q)
  ) else $error("port e enable did not take written value");

  enables_hold_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !(acc.wr_req && acc.wr_lane0) |=>
      $stable(port_c_drive_bit) &&
      $stable(port_d_drive_bit) &&
      $stable(port_e_drive_bit)
  ) else $error("pin enable changed without a write");

  other_lane_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (acc.wr_req && !acc.wr_lane0) |=>
      $stable({port_c_drive_bit, port_d_drive_bit, port_e_drive_bit})
  ) else $error("write to an upper lane changed an enable");

  read_port_c_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    rd_c_q |-> (hrdata == {24'h00_0000, port_c_drive_bit})
  ) else $error("port c read back differs from register");

  read_port_d_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    rd_d_q |-> (hrdata == {24'h00_0000, port_d_drive_bit})
  ) else $error("port d read back differs from register");

  read_port_e_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    rd_e_q |-> (hrdata == {24'h00_0000, port_e_drive_bit})
  ) else $error("port e read back differs from register");

  write_read_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (acc.wr_req && acc.wr_lane0 && acc.wr_index == IDX_PORT_C)
      ##2 (rd_c_q && !$past(acc.wr_req)) |->
      (hrdata[7:0] == $past(acc.wr_data, 2))
  ) else $error("written value not read back on port c");

  write_read_d_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (acc.wr_req && acc.wr_lane0 && acc.wr_index == IDX_PORT_D)
      ##2 (rd_d_q && !$past(acc.wr_req)) |->
      (hrdata[7:0] == $past(acc.wr_data, 2))
  ) else $error("written value not read back on port d");

  write_read_e_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (acc.wr_req && acc.wr_lane0 && acc.wr_index == IDX_PORT_E)
      ##2 (rd_e_q && !$past(acc.wr_req)) |->
      (hrdata[7:0] == $past(acc.wr_data, 2))
  ) else $error("written value not read back on port e");

  unmapped_zero_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    rd_none_q |-> (hrdata == RDATA_NONE)
  ) else $error("unmapped read did not return zero");

  bus_okay_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ##1 (hreadyout && hresp == HRESP_OKAY)
  ) else $error("slave did not answer ready and okay");

  keep_port_c_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (acc.wr_req && acc.wr_index != IDX_PORT_C) |=>
      $stable(port_c_drive_bit)
  ) else $error("write elsewhere changed port c enable");

  keep_port_d_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (acc.wr_req && acc.wr_index != IDX_PORT_D) |=>
      $stable(port_d_drive_bit)
  ) else $error("write elsewhere changed port d enable");

  keep_port_e_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (acc.wr_req && acc.wr_index != IDX_PORT_E) |=>
      $stable(port_e_drive_bit)
  ) else $error("write elsewhere changed port e enable");

  unmapped_write_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (acc.wr_req && !(|wr_hit)) |=>
      $stable({port_c_drive_bit, port_d_drive_bit, port_e_drive_bit})
  ) else $error("unmapped write changed an enable");

  hrdata_hold_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !acc.rd_req |=> $stable(hrdata)
  ) else $error("read data changed without a read");

  hrdata_upper_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    hrdata[DATA_W-1:PORT_W] == '0
  ) else $error("upper read data bits not zero");

  reset_bus_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    $rose(hresetn) |->
      (hrdata == RDATA_NONE) && hreadyout && (hresp == HRESP_OKAY)
  ) else $error("bus outputs not at reset values after reset");

  reset_hold_a: assert property (
    @(posedge hclk)
    !hresetn |->
      (port_c_drive_bit == RESET_DRIVE) &&
      (port_d_drive_bit == RESET_DRIVE) &&
      (port_e_drive_bit == RESET_DRIVE) &&
      (hrdata == RDATA_NONE)
  ) else $error("enable bits not held clear during reset");

endmodule

// File: rtl/reg_access_if.sv
// Purpose: register access strobes from the bus front end to the banks
// Assumes: read request in the address phase, write in the data phase
// Notes:   data is only the low byte lane
interface reg_access_if;
  import port_oe_pkg::*;

  logic              rd_req;
  logic [IDX_W-1:0]  rd_index;
  logic              wr_req;
  logic [IDX_W-1:0]  wr_index;
  logic              wr_lane0;
  logic [PORT_W-1:0] wr_data;

  modport bus (
    output rd_req, rd_index, wr_req, wr_index, wr_lane0, wr_data
  );
  modport regs (
    input  rd_req, rd_index, wr_req, wr_index, wr_lane0, wr_data
  );
endinterface
